/* File: core/hph_device.sv */
// Device end of the host port: strobe decode, ready, data window, DMA requests
// Functional notes
// R1 - Strobe is NOT(XOR strobes) OR chip select
// R2 - Host holds strobe until ready goes low
// R3 - Ready forced low while chip select high
// R4 - Busy shown when chip select falls mid-completion
// R5 - First window read half requests DMA, busy
// R6 - Busy after second half of completing accesses
// R7 - Other accesses keep ready low after strobe
// R8 - Control and address accesses leave ready alone
// R9 - Address strobe pulses once per strobe period
// R10 - Selects latched at strobe or address-strobe fall
// R11 - Strobe low and high at least four periods
// R12 - Read data leads ready low by two periods
// R13 - Data bus driven only during read strobe
// R14 - Address strobe low across strobe fall
// R15 - Words move as two half-word accesses
`timescale 1ns/1ps
`default_nettype none
module hph_device
   import hph_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   hph_if.dev_mp            pins,
   output var  logic        dma_req,
   output var  logic        dma_write,
   output var  logic [31:0] dma_addr,
   output var  logic [31:0] dma_wdata,
   input  wire logic        dma_ack,
   input  wire logic [31:0] dma_rdata,
   output var  logic [31:0] port_control
);

   typedef enum logic [2:0] {
      DV_IDLE, DV_ACTIVE, DV_FETCH, DV_LEAD, DV_FINISH
   } hph_dev_state_e;

   typedef struct packed {
      logic [1:0] target;
      logic       rd;
      logic       half;
   } hph_sel_s;

   function automatic logic is_window(input logic [1:0] t);
      is_window = (t == TGT_WINDOW) || (t == TGT_WINDOW_INC);
   endfunction : is_window

   function automatic logic [15:0] half_of(input logic [31:0] w, input logic h);
      half_of = (h == HALF_FIRST) ? w[15:0] : w[31:16];
   endfunction : half_of

   function automatic logic [31:0] merge_half(input logic [31:0] w, input logic h,
                                              input logic [15:0] d);
      merge_half = (h == HALF_FIRST) ? {w[31:16], d} : {d, w[15:0]};
   endfunction : merge_half

   ////////////////////////////////////////////////////////////////////////////
   // Strobe decode and select latching

   logic           strobe_n;
   logic           strobe_fall;
   logic           strobe_rise;
   logic           as_fall;
   hph_sel_s       pin_sel;
   hph_sel_s       cur_sel;

   hph_dev_state_e state_reg,     state_next;
   logic           strobe_n_reg,  strobe_n_next;
   logic           as_n_reg,      as_n_next;
   logic           as_seen_reg,   as_seen_next;
   hph_sel_s       sel_reg,       sel_next;
   hph_sel_s       acc_reg,       acc_next;
   logic           busy_reg,      busy_next;
   logic           ready_n_reg,   ready_n_next;
   logic           oe_reg,        oe_next;
   logic [15:0]    dout_reg,      dout_next;
   logic [CNT_W-1:0] cnt_reg,     cnt_next;
   logic [31:0]    window_reg,    window_next;
   logic [31:0]    addr_reg,      addr_next;
   logic [31:0]    ctrl_reg,      ctrl_next;
   logic           req_reg,       req_next;
   logic           req_wr_reg,    req_wr_next;
   logic [31:0]    wdata_reg,     wdata_next;

   assign strobe_n    = ~(pins.host_data_strobe_one ^ pins.host_data_strobe_two)
                        | pins.host_chip_select_n; // R1
   assign strobe_fall = strobe_n_reg & ~strobe_n;
   assign strobe_rise = ~strobe_n_reg & strobe_n;
   assign as_fall     = as_n_reg & ~pins.host_address_strobe_n;
   assign pin_sel     = '{target: pins.access_target_select,
                          rd:     pins.read_write_select,
                          half:   pins.halfword_select};
   // Address strobe, when used, overrides the strobe-fall sample
   assign cur_sel     = (as_seen_reg && !as_fall) ? sel_reg : pin_sel; // R10 R14

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic [31:0] src;
      logic [31:0] merged;
      src           = WORD_RESET;
      merged        = WORD_RESET;
      state_next    = state_reg;
      strobe_n_next = strobe_n;
      as_n_next     = pins.host_address_strobe_n;
      as_seen_next  = as_seen_reg;
      sel_next      = sel_reg;
      acc_next      = acc_reg;
      busy_next     = busy_reg;
      oe_next       = oe_reg;
      dout_next     = dout_reg;
      cnt_next      = cnt_reg;
      window_next   = window_reg;
      addr_next     = addr_reg;
      ctrl_next     = ctrl_reg;
      req_next      = req_reg;
      req_wr_next   = req_wr_reg;
      wdata_next    = wdata_reg;

      if (as_fall) begin
         sel_next     = pin_sel; // R10
         as_seen_next = 1'b1; // R9
      end else if (strobe_fall && !as_seen_reg) begin
         sel_next = pin_sel; // R10
      end
      if (strobe_rise && !as_fall) begin
         as_seen_next = 1'b0; // R9
      end

      case (acc_reg.target)
         TGT_CONTROL: src = ctrl_reg;
         TGT_ADDRESS: src = addr_reg;
         default:     src = window_reg;
      endcase

      case (state_reg)
         DV_IDLE: begin
            if (strobe_fall) begin
               acc_next = cur_sel;
               oe_next  = cur_sel.rd; // R13
               if (cur_sel.rd && is_window(cur_sel.target)
                   && cur_sel.half == HALF_FIRST) begin
                  req_next    = 1'b1; // R5
                  req_wr_next = 1'b0;
                  busy_next   = 1'b1; // R5
                  state_next  = DV_FETCH;
               end else begin
                  // Register accesses, window writes and second-half window reads raise no busy at strobe fall
                  state_next = DV_ACTIVE; // R7 R8
               end
            end
         end
         DV_FETCH: begin
            if (dma_ack) begin
               req_next    = 1'b0;
               window_next = dma_rdata;
               dout_next   = half_of(dma_rdata, acc_reg.half);
               cnt_next    = '0;
               state_next  = DV_LEAD;
            end
         end
         DV_LEAD: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(DATA_LEAD_CYC - 1)) begin
               busy_next  = 1'b0; // R12
               state_next = DV_ACTIVE;
            end
         end
         DV_ACTIVE: begin
            if (acc_reg.rd) begin
               dout_next = half_of(src, acc_reg.half);
            end
            if (strobe_rise) begin
               oe_next    = 1'b0; // R13
               state_next = DV_IDLE;
               if (!acc_reg.rd) begin
                  merged = merge_half(src, acc_reg.half, pins.host_data_bus); // R15
                  case (acc_reg.target)
                     TGT_CONTROL: ctrl_next   = merged;
                     TGT_ADDRESS: addr_next   = merged;
                     default:     window_next = merged;
                  endcase
               end
               if (is_window(acc_reg.target) && acc_reg.half == HALF_SECOND
                   && (!acc_reg.rd || acc_reg.target == TGT_WINDOW_INC)) begin
                  busy_next   = 1'b1; // R6
                  req_next    = !acc_reg.rd;
                  req_wr_next = 1'b1;
                  wdata_next  = merged;
                  state_next  = DV_FINISH;
               end
            end
         end
         DV_FINISH: begin
            // Auto-increment reads only need the address bump
            if (!req_reg || dma_ack) begin
               req_next  = 1'b0;
               busy_next = 1'b0;
               if (acc_reg.target == TGT_WINDOW_INC) begin
                  addr_next = addr_reg + ADDR_STEP;
               end
               state_next = DV_IDLE;
            end
         end
         default: state_next = DV_IDLE;
      endcase

      // Busy only reaches the pin while chip select is low
      ready_n_next = busy_next & ~pins.host_chip_select_n; // R3 R4
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= DV_IDLE;
         strobe_n_reg <= 1'b1;
         as_n_reg     <= 1'b1;
         as_seen_reg  <= 1'b0;
         sel_reg      <= '0;
         acc_reg      <= '0;
         busy_reg     <= 1'b0;
         ready_n_reg  <= 1'b0;
         oe_reg       <= 1'b0;
         dout_reg     <= HALF_RESET;
         cnt_reg      <= '0;
         window_reg   <= WORD_RESET;
         addr_reg     <= WORD_RESET;
         ctrl_reg     <= WORD_RESET;
         req_reg      <= 1'b0;
         req_wr_reg   <= 1'b0;
         wdata_reg    <= WORD_RESET;
      end else begin
         state_reg    <= state_next;
         strobe_n_reg <= strobe_n_next;
         as_n_reg     <= as_n_next;
         as_seen_reg  <= as_seen_next;
         sel_reg      <= sel_next;
         acc_reg      <= acc_next;
         busy_reg     <= busy_next;
         ready_n_reg  <= ready_n_next;
         oe_reg       <= oe_next;
         dout_reg     <= dout_next;
         cnt_reg      <= cnt_next;
         window_reg   <= window_next;
         addr_reg     <= addr_next;
         ctrl_reg     <= ctrl_next;
         req_reg      <= req_next;
         req_wr_reg   <= req_wr_next;
         wdata_reg    <= wdata_next;
      end
   end

   assign pins.host_ready_n       = ready_n_reg;
   assign pins.host_data_from_dev = dout_reg;
   assign pins.host_data_oe_dev   = oe_reg;
   assign dma_req                 = req_reg;
   assign dma_write               = req_wr_reg;
   assign dma_addr                = addr_reg;
   assign dma_wdata               = wdata_reg;
   assign port_control            = ctrl_reg;

endmodule : hph_device
`default_nettype wire

/* File: core/hph_host.sv */
// Host end of the host port: runs one 32-bit access as two half-word cycles
`timescale 1ns/1ps
`default_nettype none
module hph_host
   import hph_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   hph_if.host_mp           pins,
   input  wire logic        cmd_valid,
   output var  logic        cmd_ready,
   input  wire logic [1:0]  cmd_target,
   input  wire logic        cmd_write,
   input  wire logic        cmd_use_as,
   input  wire logic [31:0] cmd_wdata,
   output var  logic        resp_valid,
   output var  logic [31:0] resp_rdata
);

   typedef enum logic [1:0] {HS_IDLE, HS_SELECT, HS_LOW, HS_HIGH} hph_host_state_e;

   hph_host_state_e  state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg,   cnt_next;
   logic             cs_n_reg,  cs_n_next;
   logic             ds1_reg,   ds1_next;
   logic             as_n_reg,  as_n_next;
   logic             half_reg,  half_next;
   logic [1:0]       tgt_reg,   tgt_next;
   logic             wr_reg,    wr_next;
   logic             use_as_reg, use_as_next;
   logic [31:0]      word_reg,  word_next;
   logic             rdy_reg,   rdy_next;
   logic             resp_reg,  resp_next;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      cs_n_next   = cs_n_reg;
      ds1_next    = ds1_reg;
      as_n_next   = as_n_reg;
      half_next   = half_reg;
      tgt_next    = tgt_reg;
      wr_next     = wr_reg;
      use_as_next = use_as_reg;
      word_next   = word_reg;
      rdy_next    = rdy_reg;
      resp_next   = 1'b0;
      case (state_reg)
         HS_IDLE: begin
            if (cmd_valid && rdy_reg) begin
               rdy_next    = 1'b0;
               tgt_next    = cmd_target;
               wr_next     = cmd_write;
               use_as_next = cmd_use_as;
               word_next   = cmd_write ? cmd_wdata : WORD_RESET;
               half_next   = HALF_FIRST; // R15
               cs_n_next   = 1'b0;
               cnt_next    = '0;
               state_next  = HS_SELECT;
            end
         end
         HS_SELECT: begin
            // Ready lags chip select, so let it settle before trusting it
            if (cnt_reg != CNT_W'(SELECT_SETTLE_CYC)) begin
               cnt_next = cnt_reg + 1'b1;
            end else if (!pins.host_ready_n) begin // R4
               as_n_next = ~use_as_reg; // R14
               if (as_n_reg != use_as_reg) begin
                  ds1_next   = 1'b0;
                  cnt_next   = '0;
                  state_next = HS_LOW;
               end
            end
         end
         HS_LOW: begin
            if (cnt_reg != CNT_W'(STROBE_LOW_CYC - 1)) begin
               cnt_next = cnt_reg + 1'b1;
            end
            if (cnt_reg == '0) begin
               as_n_next = 1'b1; // R9 R14
            end
            if (cnt_reg == CNT_W'(STROBE_LOW_CYC - 1) && !pins.host_ready_n) begin // R2 R11
               ds1_next = 1'b1;
               if (!wr_reg) begin
                  if (half_reg == HALF_FIRST) begin
                     word_next[15:0] = pins.host_data_bus;
                  end else begin
                     word_next[31:16] = pins.host_data_bus;
                  end
               end
               cnt_next   = '0;
               state_next = HS_HIGH;
            end
         end
         HS_HIGH: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(STROBE_HIGH_CYC - 1)) begin // R11
               cnt_next = '0;
               if (half_reg == HALF_FIRST) begin
                  half_next  = HALF_SECOND; // R15
                  state_next = HS_SELECT;
               end else begin
                  cs_n_next  = 1'b1;
                  resp_next  = 1'b1;
                  rdy_next   = 1'b1;
                  state_next = HS_IDLE;
               end
            end
         end
         default: state_next = HS_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= HS_IDLE;
         cnt_reg    <= '0;
         cs_n_reg   <= 1'b1;
         ds1_reg    <= 1'b1;
         as_n_reg   <= 1'b1;
         half_reg   <= HALF_FIRST;
         tgt_reg    <= TGT_CONTROL;
         wr_reg     <= 1'b0;
         use_as_reg <= 1'b0;
         word_reg   <= WORD_RESET;
         rdy_reg    <= 1'b1;
         resp_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         cs_n_reg   <= cs_n_next;
         ds1_reg    <= ds1_next;
         as_n_reg   <= as_n_next;
         half_reg   <= half_next;
         tgt_reg    <= tgt_next;
         wr_reg     <= wr_next;
         use_as_reg <= use_as_next;
         word_reg   <= word_next;
         rdy_reg    <= rdy_next;
         resp_reg   <= resp_next;
      end
   end

   // Second data strobe parks high; the first one alone toggles the strobe
   assign pins.host_chip_select_n    = cs_n_reg;
   assign pins.host_data_strobe_one  = ds1_reg;
   assign pins.host_data_strobe_two  = 1'b1;
   assign pins.host_address_strobe_n = as_n_reg;
   assign pins.access_target_select  = tgt_reg; // R10
   assign pins.read_write_select     = ~wr_reg;
   assign pins.halfword_select       = half_reg;
   assign pins.host_data_from_host   = (half_reg == HALF_FIRST) ? word_reg[15:0]
                                                                : word_reg[31:16];
   assign pins.host_data_oe_host     = wr_reg & (state_reg != HS_IDLE);
   assign cmd_ready                  = rdy_reg;
   assign resp_valid                 = resp_reg;
   assign resp_rdata                 = word_reg;

endmodule : hph_host
`default_nettype wire

/* File: core/hph_if.sv */
// Pin-level interface joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface hph_if;
   logic        host_chip_select_n;
   logic        host_data_strobe_one;
   logic        host_data_strobe_two;
   logic        host_address_strobe_n;
   logic [1:0]  access_target_select;
   logic        read_write_select;
   logic        halfword_select;
   logic        host_ready_n;
   logic [15:0] host_data_from_host;
   logic        host_data_oe_host;
   logic [15:0] host_data_from_dev;
   logic        host_data_oe_dev;
   logic [15:0] host_data_bus;

   // Undriven bus reads as zero
   assign host_data_bus = host_data_oe_dev  ? host_data_from_dev  :
                          host_data_oe_host ? host_data_from_host : 16'h0000;

   modport dev_mp (
      input  host_chip_select_n,
      input  host_data_strobe_one,
      input  host_data_strobe_two,
      input  host_address_strobe_n,
      input  access_target_select,
      input  read_write_select,
      input  halfword_select,
      input  host_data_bus,
      output host_ready_n,
      output host_data_from_dev,
      output host_data_oe_dev
   );

   modport host_mp (
      output host_chip_select_n,
      output host_data_strobe_one,
      output host_data_strobe_two,
      output host_address_strobe_n,
      output access_target_select,
      output read_write_select,
      output halfword_select,
      input  host_data_bus,
      input  host_ready_n,
      output host_data_from_host,
      output host_data_oe_host
   );
endinterface : hph_if
`default_nettype wire

/* File: core/hph_pkg.sv */
// Constants shared by both ends of the host port handshake
package hph_pkg;

   localparam int unsigned CLK_PERIOD_NS  = 40;
   // Host strobe low and high times, in CPU clock periods
   localparam int unsigned STROBE_LOW_P   = 4;
   localparam int unsigned STROBE_HIGH_P  = 4;
   // Read data leads the ready edge by this many CPU clock periods
   localparam int unsigned DATA_LEAD_P    = 2;
   localparam int unsigned STROBE_LOW_NS  = STROBE_LOW_P * CLK_PERIOD_NS;
   localparam int unsigned STROBE_HIGH_NS = STROBE_HIGH_P * CLK_PERIOD_NS;
   localparam int unsigned DATA_LEAD_NS   = DATA_LEAD_P * CLK_PERIOD_NS;
   localparam int unsigned STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DATA_LEAD_CYC  = DATA_LEAD_NS / CLK_PERIOD_NS;
   // Host waits this long after chip select falls before trusting ready
   localparam int unsigned SELECT_SETTLE_CYC = 2;
   localparam int unsigned CNT_W          = 4;

   // Target selector encodings
   localparam logic [1:0] TGT_CONTROL    = 2'h0;
   localparam logic [1:0] TGT_WINDOW_INC = 2'h1;
   localparam logic [1:0] TGT_ADDRESS    = 2'h2;
   localparam logic [1:0] TGT_WINDOW     = 2'h3;

   // Half-word select: first half carries bits 15:0
   localparam logic HALF_FIRST  = 1'h0;
   localparam logic HALF_SECOND = 1'h1;

   localparam logic [31:0] ADDR_STEP       = 32'h0000_0004;
   localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET      = 16'h0000;

endpackage : hph_pkg

/* File: verification/host_port_handshake_test.sv */
// Bench joining host end and device end, with a DMA memory and a word model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module host_port_handshake_test
   import hph_pkg::*;
;
   logic        mclk = 1'b0, arst_n = 1'b0;
   logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_use_as = 1'b0, dma_ack = 1'b0;
   logic [1:0]  cmd_target = 2'h0;
   logic [3:0]  k;
   logic [31:0] cmd_wdata = 32'h0, dma_rdata = 32'h0, m_ctl = 32'h0, m_addr = 32'h0;
   logic [31:0] port_control, dma_addr, dma_wdata, resp_rdata;
   logic        cmd_ready, resp_valid, dma_req, dma_write;
   logic [31:0] dev_mem [logic [31:0]];
   logic [31:0] mdl_mem [logic [31:0]];
   integer      seed = 97, n_mismatch = 0, compares = 0;
   // Expected DMA requests in order: {write, address, write data}
   logic [64:0] dma_q [$];
   logic [64:0] dma_e;

   always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

   hph_if hph_if_i ();
   hph_host hph_host_i (.mclk(mclk), .arst_n(arst_n), .pins(hph_if_i.host_mp),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_target(cmd_target),
      .cmd_write(cmd_write), .cmd_use_as(cmd_use_as), .cmd_wdata(cmd_wdata),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata));
   hph_device hph_device_i (.mclk(mclk), .arst_n(arst_n), .pins(hph_if_i.dev_mp),
      .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
      .dma_ack(dma_ack), .dma_rdata(dma_rdata), .port_control(port_control));
   hph_handshake_sva hph_handshake_sva_i (.mclk(mclk), .arst_n(arst_n),
      .host_chip_select_n(hph_if_i.host_chip_select_n),
      .host_data_strobe_one(hph_if_i.host_data_strobe_one),
      .host_data_strobe_two(hph_if_i.host_data_strobe_two),
      .host_address_strobe_n(hph_if_i.host_address_strobe_n),
      .access_target_select(hph_if_i.access_target_select),
      .read_write_select(hph_if_i.read_write_select),
      .halfword_select(hph_if_i.halfword_select), .host_ready_n(hph_if_i.host_ready_n),
      .host_data_bus(hph_if_i.host_data_bus), .host_data_oe_dev(hph_if_i.host_data_oe_dev));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // Slow answers keep the device busy when the next select falls
   initial forever begin
      @(negedge mclk);
      dma_ack = 1'b0;
      if (dma_req === 1'b1) begin
         repeat ({$random(seed)} % 8) @(negedge mclk);
         // A late write may finish after the next command has begun
         dma_e = (dma_q.size() > 0) ? dma_q.pop_front() : {1'b1, ~dma_addr, 32'h0};
         `CHK(dma_addr, dma_e[63:32])
         `CHK(dma_write, dma_e[64])
         if (dma_write === 1'b1) begin
            `CHK(dma_wdata, dma_e[31:0])
            dev_mem[dma_addr] = dma_wdata;
         end else begin
            dma_rdata = dev_mem.exists(dma_addr) ? dev_mem[dma_addr] : ~dma_addr;
         end
         dma_ack = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One command; the model settles after the answer, as the address bumps late
   task automatic run(input logic [1:0] t, input logic w, input logic a, input logic [31:0] d);
      logic [31:0] exp;
      int          n;
      exp = w ? d : (t == TGT_CONTROL) ? m_ctl : (t == TGT_ADDRESS) ? m_addr :
         mdl_mem.exists(m_addr) ? mdl_mem[m_addr] : ~m_addr;
      n = 0;
      if (t[0]) dma_q.push_back({w, m_addr, d});
      cmd_target = t;
      cmd_write = w;
      cmd_use_as = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 400) begin
         n_mismatch++;
         end_sim;
      end
      if (w && t == TGT_CONTROL) m_ctl = d;
      if (w && t == TGT_ADDRESS) m_addr = d;
      if (w && t[0]) mdl_mem[m_addr] = d;
      if (t == TGT_WINDOW_INC) m_addr = m_addr + ADDR_STEP;
      `CHK(resp_rdata, exp)
      `CHK(port_control, m_ctl)
   endtask : run

   initial begin
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
      `CHK(port_control, WORD_RESET)
      for (int i = 0; i < 56; i++) begin
         k = (i < 16) ? i[3:0] : 4'($random(seed));
         run(k[1:0], k[2], k[3], $random(seed));
         $display("test %0d done", i);
      end
      end_sim;
   end

   initial begin
      #800000;
      n_mismatch++;
      end_sim;
   end
endmodule : host_port_handshake_test
`default_nettype wire

/* File: verification/hph_handshake_sva.sv */
// Checker of the host port pin handshake
`timescale 1ns/1ps
`default_nettype none
module hph_handshake_sva
   import hph_pkg::*;
(
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        host_chip_select_n,
   input wire logic        host_data_strobe_one,
   input wire logic        host_data_strobe_two,
   input wire logic        host_address_strobe_n,
   input wire logic [1:0]  access_target_select,
   input wire logic        read_write_select,
   input wire logic        halfword_select,
   input wire logic        host_ready_n,
   input wire logic [15:0] host_data_bus,
   input wire logic        host_data_oe_dev
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Combined strobe, active low
   wire stb_n = ~(host_data_strobe_one ^ host_data_strobe_two) | host_chip_select_n;
   sequence as_lead;
      $fell(host_address_strobe_n) && stb_n;
   endsequence
   sequence as_trail;
      ##[1:2] $fell(stb_n) ##[1:2] $rose(host_address_strobe_n);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // One cycle of lag allowed for the registered qualification
   AST_RDY_CS: assert property (host_chip_select_n [*2] |-> !host_ready_n)
      else $error("ready not low while deselected");
   AST_STB_LOW: assert property ($fell(stb_n) |-> !stb_n [*4])
      else $error("strobe low too short");
   AST_STB_HIGH: assert property ($rose(stb_n) |-> stb_n [*4])
      else $error("strobe high too short");
   AST_HOLD: assert property ($rose(stb_n) |-> !$past(host_ready_n))
      else $error("strobe released before ready");
   AST_OE_RD: assert property (host_data_oe_dev |-> read_write_select
      && (!stb_n || !$past(stb_n, 2)))
      else $error("data bus driven outside read");
   AST_BUSY_RD: assert property ($fell(stb_n) && read_write_select
      && access_target_select[0] && !halfword_select |-> ##[1:3] host_ready_n)
      else $error("no busy on window read");
   AST_DATA_LEAD: assert property ($fell(host_ready_n) && !stb_n && read_write_select |->
      host_data_bus == $past(host_data_bus, 2))
      else $error("read data not ahead of ready");
   AST_BUSY_DONE: assert property ($rose(stb_n) && halfword_select
      && access_target_select[0] && (!read_write_select || !access_target_select[1])
      |-> ##[1:3] host_ready_n)
      else $error("no busy after second half");
   AST_QUIET: assert property ($rose(stb_n) && !access_target_select[0] |->
      !host_ready_n [*3])
      else $error("busy on register access");
   AST_AS_ONCE: assert property (as_lead |-> as_trail)
      else $error("address strobe misplaced");
endmodule : hph_handshake_sva
`default_nettype wire
